//--- hdl/pcmcd_defs.svh
// Purpose: Offsets, field positions, reset values and codes of the PCM codec control block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef PCMCD_DEFS_SVH
`define PCMCD_DEFS_SVH

// Register byte offsets
`define PCMCD_CTRL_OFS 4'h0
`define PCMCD_TXDATA_OFS 4'h4
`define PCMCD_RXDATA_OFS 4'h8
`define PCMCD_STATUS_OFS 4'hC

// Control field positions
`define PCMCD_CTRL_TXPD 0
`define PCMCD_CTRL_RXPD 1
`define PCMCD_CTRL_MULAW 2
`define PCMCD_CTRL_TXUNITY 3
`define PCMCD_CTRL_RXBOOST 4
`define PCMCD_CTRL_W 5

// Both halves on, mu-law, transmit 0 dB, receive 0 dB
`define PCMCD_CTRL_RST 5'h0C

// Receive data and status fields
`define PCMCD_RXDATA_NEW 8
`define PCMCD_STAT_TXON 16
`define PCMCD_STAT_RXON 17

// Companding masks and word length
`define PCMCD_MAG_MASK 8'h7F
`define PCMCD_ADI_MASK 8'h55
`define PCMCD_LAST_BIT 3'h7

`endif

//--- hdl/pcmcd_pkg.sv
// Purpose: Types shared by the PCM codec control block
// Assumes: Constants live in pcmcd_defs.svh
// Notes: Field order of pcmcd_cfg_t matches the control register bits
package pcmcd_pkg;

  typedef enum logic {
    LNK_IDLE,
    LNK_SHIFT
  } pcmcd_lnk_t;

  typedef struct packed {
    logic rx_boost;
    logic tx_unity;
    logic mu_law;
    logic rx_pd;
    logic tx_pd;
  } pcmcd_cfg_t;

  typedef struct packed {
    pcmcd_cfg_t cfg;
    logic [7:0] word;
  } pcmcd_frm_t;

  typedef struct packed {
    logic tx_on;
    logic rx_on;
    logic [7:0] word;
  } pcmcd_res_t;

endpackage

//--- hdl/pcmcd_top.sv
// Purpose: Digital control and serial side of a single-channel voice PCM codec
// Assumes: Bit clock bclk runs continuously; frame sync, address and serial data are
//   synchronous to it and sampled on its rising edge
// Notes: Settings and the transmit word cross to bclk by a toggle handshake per frame
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "pcmcd_defs.svh"

module pcmcd_top
  import pcmcd_pkg::*;
#(
  parameter int FCNT_W = 16
) (
  // System clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // PCM bus, bit clock domain
  input wire logic bclk,
  input wire logic frame_sync_in,
  input wire logic channel_address_in,
  input wire logic pcm_serial_in,
  output logic pcm_serial_out,
  output logic pcm_serial_oe,
  // Analog side controls, bit clock domain
  output logic analog_receive_out_ground,
  output logic tx_atten_3db,
  output logic rx_boost_3db
);

  if (FCNT_W < 1 || FCNT_W > 16) begin : g_chk
    $error("FCNT_W must lie between 1 and 16");
  end

  // Same xor encodes and decodes, so it serves both directions
  function automatic logic [7:0] line_code(input logic mu, input logic [7:0] w);
    line_code = mu ? (w ^ `PCMCD_MAG_MASK) : (w ^ `PCMCD_ADI_MASK);
  endfunction

  // ---------------- System clock domain ----------------
  logic wait_q;
  logic [31:0] rdata_q;
  logic [`PCMCD_CTRL_W-1:0] ctrl_q;
  logic [7:0] txdata_q, rxdata_q;
  logic rxnew_q, stat_txon_q, stat_rxon_q;
  logic [FCNT_W-1:0] fcnt_q;
  pcmcd_frm_t push_q;
  logic ack_tgl_q, init_q;
  logic done_s1_q, done_s2_q, done_s3_q;
  logic [31:0] rd_mux;
  logic req, acc_wr, acc_rd, done_ev, push_ev;

  // Bit clock domain signals read across the crossing
  logic done_tgl_q;
  pcmcd_res_t res_q;

  assign req = avs_read | avs_write;
  assign acc_wr = avs_write & ~wait_q;
  assign acc_rd = avs_read & ~wait_q;
  assign done_ev = done_s2_q ^ done_s3_q;
  assign push_ev = init_q | done_ev;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `PCMCD_CTRL_OFS: rd_mux[`PCMCD_CTRL_W-1:0] = ctrl_q;
      `PCMCD_TXDATA_OFS: rd_mux[7:0] = txdata_q;
      `PCMCD_RXDATA_OFS: begin
        rd_mux[7:0] = rxdata_q;
        rd_mux[`PCMCD_RXDATA_NEW] = rxnew_q;
      end
      `PCMCD_STATUS_OFS: begin
        rd_mux[FCNT_W-1:0] = fcnt_q;
        rd_mux[`PCMCD_STAT_TXON] = stat_txon_q;
        rd_mux[`PCMCD_STAT_RXON] = stat_rxon_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait state per access, then one cycle with waitrequest low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= `PCMCD_CTRL_RST;
      txdata_q <= 8'h00;
    end else if (acc_wr && avs_byteenable[0]) begin
      if (avs_address == `PCMCD_CTRL_OFS) begin
        ctrl_q <= avs_writedata[`PCMCD_CTRL_W-1:0];
      end
      if (avs_address == `PCMCD_TXDATA_OFS) begin
        txdata_q <= avs_writedata[7:0];
      end
    end
  end

  // Frame-done event from the bit clock side
  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      done_s1_q <= done_tgl_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  // Results are stable on the bit clock side until the next frame ends
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxdata_q <= 8'h00;
      fcnt_q <= '0;
      stat_txon_q <= 1'b0;
      stat_rxon_q <= 1'b0;
    end else if (done_ev) begin
      fcnt_q <= fcnt_q + 1'b1;
      stat_txon_q <= res_q.tx_on;
      stat_rxon_q <= res_q.rx_on;
      if (res_q.rx_on) begin
        rxdata_q <= res_q.word;
      end
    end
  end

  // New-word flag: a new word wins over a read that clears it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxnew_q <= 1'b0;
    end else if (done_ev && res_q.rx_on) begin
      rxnew_q <= 1'b1;
    end else if (acc_rd && avs_address == `PCMCD_RXDATA_OFS) begin
      rxnew_q <= 1'b0;
    end
  end

  // Settings and next transmit word offered once after reset and after each frame
  always_ff @(posedge clk) begin
    if (!nrst) begin
      push_q <= '{cfg: `PCMCD_CTRL_RST, word: 8'h00};
      ack_tgl_q <= 1'b0;
      init_q <= 1'b1;
    end else if (push_ev) begin
      push_q <= '{cfg: pcmcd_cfg_t'(ctrl_q), word: txdata_q};
      ack_tgl_q <= ~ack_tgl_q;
      init_q <= 1'b0;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // ---------------- Bit clock domain ----------------
  logic lrst1_q, lrst2_q;
  logic ack_s1_q, ack_s2_q, ack_s3_q;
  pcmcd_frm_t cur_q;
  pcmcd_lnk_t st_q;
  logic [2:0] cnt_q;
  logic fs_prev_q, frm_txon_q, frm_rxon_q;
  logic [7:0] tsh_q, rsh_q;
  logic dout_q, doe_q, agnd_q, txatt_q, rxbst_q;
  logic [7:0] tx_enc;
  logic start, last;

  assign tx_enc = line_code(cur_q.cfg.mu_law, cur_q.word);
  assign start = (st_q == LNK_IDLE) && frame_sync_in && !fs_prev_q
                 && !channel_address_in;
  assign last = (st_q == LNK_SHIFT) && (cnt_q == `PCMCD_LAST_BIT);

  // Reset carried into the bit clock domain
  always_ff @(posedge bclk) begin
    lrst1_q <= nrst;
    lrst2_q <= lrst1_q;
  end

  always_ff @(posedge bclk) begin
    if (!lrst2_q) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  // Settings take effect between frames
  always_ff @(posedge bclk) begin
    if (!lrst2_q) begin
      cur_q <= '{cfg: `PCMCD_CTRL_RST, word: 8'h00};
    end else if (ack_s2_q ^ ack_s3_q) begin
      cur_q <= push_q;
    end
  end

  // Analog side controls follow the applied settings
  always_ff @(posedge bclk) begin
    if (!lrst2_q) begin
      agnd_q <= 1'b0;
      txatt_q <= 1'b0;
      rxbst_q <= 1'b0;
    end else begin
      agnd_q <= cur_q.cfg.rx_pd;
      txatt_q <= ~cur_q.cfg.tx_unity;
      rxbst_q <= cur_q.cfg.rx_boost;
    end
  end

  always_ff @(posedge bclk) begin
    if (!lrst2_q) begin
      fs_prev_q <= 1'b0;
    end else begin
      fs_prev_q <= frame_sync_in;
    end
  end

  // Frame sequencer
  always_ff @(posedge bclk) begin
    if (!lrst2_q) begin
      st_q <= LNK_IDLE;
      cnt_q <= 3'h0;
      frm_txon_q <= 1'b0;
      frm_rxon_q <= 1'b0;
    end else begin
      case (st_q)
        LNK_IDLE: begin
          if (start) begin
            st_q <= LNK_SHIFT;
            cnt_q <= 3'h0;
            frm_txon_q <= ~cur_q.cfg.tx_pd;
            frm_rxon_q <= ~cur_q.cfg.rx_pd;
          end
        end
        LNK_SHIFT: begin
          if (last) begin
            st_q <= LNK_IDLE;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        default: st_q <= LNK_IDLE;
      endcase
    end
  end

  // Transmit shifter and three-state output, MSB first
  always_ff @(posedge bclk) begin
    if (!lrst2_q) begin
      tsh_q <= 8'h00;
      dout_q <= 1'b0;
      doe_q <= 1'b0;
    end else if (start) begin
      tsh_q <= cur_q.cfg.tx_pd ? 8'h00 : tx_enc;
      dout_q <= cur_q.cfg.tx_pd ? 1'b0 : tx_enc[7];
      doe_q <= ~cur_q.cfg.tx_pd;
    end else if (last) begin
      dout_q <= 1'b0;
      doe_q <= 1'b0;
    end else if (st_q == LNK_SHIFT) begin
      tsh_q <= {tsh_q[6:0], 1'b0};
      dout_q <= tsh_q[6];
    end
  end

  // Receive shifter, idle while the receive half is down
  always_ff @(posedge bclk) begin
    if (!lrst2_q) begin
      rsh_q <= 8'h00;
    end else if (st_q == LNK_SHIFT && frm_rxon_q) begin
      rsh_q <= {rsh_q[6:0], pcm_serial_in};
    end
  end

  // Frame result handed to the system clock side
  always_ff @(posedge bclk) begin
    if (!lrst2_q) begin
      res_q <= '{tx_on: 1'b0, rx_on: 1'b0, word: 8'h00};
      done_tgl_q <= 1'b0;
    end else if (last) begin
      res_q.tx_on <= frm_txon_q;
      res_q.rx_on <= frm_rxon_q;
      if (frm_rxon_q) begin
        res_q.word <= line_code(cur_q.cfg.mu_law, {rsh_q[6:0], pcm_serial_in});
      end
      done_tgl_q <= ~done_tgl_q;
    end
  end

  assign pcm_serial_out = dout_q;
  assign pcm_serial_oe = doe_q;
  assign analog_receive_out_ground = agnd_q;
  assign tx_atten_3db = txatt_q;
  assign rx_boost_3db = rxbst_q;

endmodule // pcmcd_top

//--- verification/pcmcd_props.sv
// Purpose: Port checks for pcmcd_top
// Assumes: Bound to every pcmcd_top instance
// Notes: Bus checks on clk, link checks on bclk
`timescale 1ns/1ps
module pcmcd_props (
  // Clocks and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic bclk,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Link
  input wire logic frame_sync_in,
  input wire logic channel_address_in,
  input wire logic pcm_serial_out,
  input wire logic pcm_serial_oe,
  input wire logic analog_receive_out_ground,
  input wire logic tx_atten_3db,
  input wire logic rx_boost_3db
);
  bus_answer_a: assert property (@(posedge clk) disable iff (!nrst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  wait_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  read_upper_a: assert property (@(posedge clk) disable iff (!nrst)
    avs_readdata[31:18] == 14'h0)
    else $error("read data upper bits set");
  frame_len_a: assert property (@(posedge bclk) disable iff (!nrst)
    $rose(pcm_serial_oe) |-> pcm_serial_oe [*8] ##1 !pcm_serial_oe)
    else $error("slot length not eight bits");
  out_quiet_a: assert property (@(posedge bclk) disable iff (!nrst)
    !pcm_serial_oe |-> !pcm_serial_out)
    else $error("serial out active while released");
  sync_gate_a: assert property (@(posedge bclk) disable iff (!nrst)
    $rose(pcm_serial_oe) |-> $past(frame_sync_in) && !$past(frame_sync_in, 2)
    && !$past(channel_address_in))
    else $error("slot started without accepted sync");
  addr_block_a: assert property (@(posedge bclk) disable iff (!nrst)
    frame_sync_in && !$past(frame_sync_in) && channel_address_in |=> !$rose(pcm_serial_oe))
    else $error("sync honoured with address high");
  set_steady_a: assert property (@(posedge bclk) disable iff (!nrst)
    pcm_serial_oe && $past(pcm_serial_oe) |->
    $stable({tx_atten_3db, rx_boost_3db, analog_receive_out_ground}))
    else $error("settings changed inside a frame");
endmodule // pcmcd_props

bind pcmcd_top pcmcd_props props_u (.clk(clk), .nrst(nrst), .bclk(bclk),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .frame_sync_in(frame_sync_in),
  .channel_address_in(channel_address_in), .pcm_serial_out(pcm_serial_out),
  .pcm_serial_oe(pcm_serial_oe), .analog_receive_out_ground(analog_receive_out_ground),
  .tx_atten_3db(tx_atten_3db), .rx_boost_3db(rx_boost_3db));

//--- verification/pcmcd_ctl_model.sv
// Purpose: PCM bus controller model on the bit clock
// Assumes: Bit clock is made by the bench
// Notes: Released receive line shows the inverse of its last bit
`timescale 1ns/1ps
module pcmcd_ctl_model (
  // Bit clock
  input wire logic bclk,
  // Bus lines
  output logic frame_sync_in,
  output logic channel_address_in,
  output logic pcm_serial_in,
  input wire logic pcm_serial_out,
  input wire logic pcm_serial_oe
);
  initial begin
    frame_sync_in = 1'b0;
    channel_address_in = 1'b0;
    pcm_serial_in = 1'b0;
  end

  // One frame: sync two bit periods, eight bits MSB first each way
  task automatic frame(input logic adr, input logic [7:0] rx, output logic [7:0] tx,
    output int n_oe);
    n_oe = 0;
    tx = 8'h00;
    @(posedge bclk);
    frame_sync_in <= 1'b1;
    channel_address_in <= adr;
    @(posedge bclk);
    pcm_serial_in <= rx[7];
    for (int i = 0; i < 8; i++) begin
      // Mid-bit sample: the value that stands at the next rising edge
      @(negedge bclk);
      tx[7 - i] = pcm_serial_out;
      n_oe += (pcm_serial_oe === 1'b1);
      @(posedge bclk);
      if (i == 0) frame_sync_in <= 1'b0;
      pcm_serial_in <= (i < 7) ? rx[6 - i] : ~rx[0];
    end
    channel_address_in <= 1'b0;
    repeat (6) @(posedge bclk);
  endtask
endmodule // pcmcd_ctl_model

//--- verification/pcmcd_top_test.sv
// Purpose: Self-checking bench for pcmcd_top
// Assumes: Bit clock 32 ns, free of the 25 ns system clock
// Notes: Each setting is used one frame after it is written
`timescale 1ns/1ps
`include "pcmcd_defs.svh"
module pcmcd_top_test;
  logic clk, nrst, bclk, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic frame_sync_in, channel_address_in, pcm_serial_in, pcm_serial_out, pcm_serial_oe;
  logic analog_receive_out_ground, tx_atten_3db, rx_boost_3db;
  int num_errors = 0;
  int n_compared = 0;
  int nf = 0;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    bclk = 1'b0;
    #3;
    forever #16 bclk = ~bclk;
  end

  pcmcd_top dut_u (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bclk(bclk), .frame_sync_in(frame_sync_in),
    .channel_address_in(channel_address_in), .pcm_serial_in(pcm_serial_in),
    .pcm_serial_out(pcm_serial_out), .pcm_serial_oe(pcm_serial_oe),
    .analog_receive_out_ground(analog_receive_out_ground),
    .tx_atten_3db(tx_atten_3db), .rx_boost_3db(rx_boost_3db));
  pcmcd_ctl_model ctl_u (.bclk(bclk), .frame_sync_in(frame_sync_in),
    .channel_address_in(channel_address_in), .pcm_serial_in(pcm_serial_in),
    .pcm_serial_out(pcm_serial_out), .pcm_serial_oe(pcm_serial_oe));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One bus access; read data lands in q
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] be = 4'hF);
    int n;
    logic w;
    n = 0;
    w = 1'b1;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    // Sample settled outputs inside the cycle that ends at the next edge
    do begin
      #1;
      w = avs_waitrequest;
      q = avs_readdata;
      @(posedge clk);
      n++;
    end while (w !== 1'b0 && n < 50);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (w !== 1'b0) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  // Set control, pass one frame, then judge the next one
  task automatic xfer(input logic [4:0] c);
    logic [7:0] m, tx;
    int n;
    m = c[2] ? 8'h7F : 8'h55;
    bus(1, `PCMCD_CTRL_OFS, {27'h0, c});
    bus(1, `PCMCD_TXDATA_OFS, 32'hA5);
    ctl_u.frame(1'b0, 8'h00, tx, n);
    bus(0, `PCMCD_RXDATA_OFS, 0);
    ctl_u.frame(1'b0, 8'h3C, tx, n);
    nf += 2;
    check(n, c[0] ? 0 : 8);
    check(tx, c[0] ? 8'h00 : 8'hA5 ^ m);
    bus(0, `PCMCD_RXDATA_OFS, 0);
    check(q[8], {~c[1]});
    if (!c[1]) check(q[7:0], 8'h3C ^ m);
    bus(0, `PCMCD_STATUS_OFS, 0);
    check(q[17:16], {~c[1], ~c[0]});
    check({analog_receive_out_ground, tx_atten_3db, rx_boost_3db}, {c[1], ~c[3], c[4]});
  endtask

  task automatic t_regs();
    check({analog_receive_out_ground, tx_atten_3db, rx_boost_3db}, 3'h0);
    bus(0, `PCMCD_CTRL_OFS, 0);
    check(q, {27'h0, `PCMCD_CTRL_RST});
    bus(0, `PCMCD_TXDATA_OFS, 0);
    check(q, 32'h0);
    bus(1, 4'h2, 32'hFFFFFFFF);
    bus(0, 4'h2, 0);
    check(q, 32'h0);
    bus(1, `PCMCD_CTRL_OFS, 32'h1F, 4'hE);
    bus(0, `PCMCD_CTRL_OFS, 0);
    check(q, {27'h0, `PCMCD_CTRL_RST});
  endtask

  task automatic t_law();
    xfer(5'h0C);
    xfer(5'h08);
  endtask

  task automatic t_gain();
    xfer(5'h14);
    xfer(5'h18);
  endtask

  task automatic t_pdown();
    xfer(5'h0D);
    xfer(5'h0E);
    xfer(5'h0F);
    xfer(5'h0C);
  endtask

  task automatic t_addr();
    logic [7:0] tx;
    int n;
    ctl_u.frame(1'b1, 8'h11, tx, n);
    check(n, 0);
    bus(0, `PCMCD_STATUS_OFS, 0);
    check(q[15:0], nf[15:0]);
    ctl_u.frame(1'b0, 8'h11, tx, n);
    check(n, 8);
    bus(0, `PCMCD_STATUS_OFS, 0);
    check(q[15:0], nf[15:0] + 16'h1);
  endtask

  initial begin
    nrst = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    repeat (8) @(posedge bclk);
    t_law();
    t_gain();
    t_pdown();
    t_addr();
    report_and_stop();
  end
endmodule // pcmcd_top_test
